// ===== design/ophy_tx_port.sv
// Top of the octal transmit port: clock source, link capture and Wishbone registers.
// Assumes link_clk is the clock that times transmit data in the active mode.
// Function
// - A running 25 MHz crystal input becomes the clock source.
// - With the crystal running, the reference pin drives a 50 MHz output.
// - RMII di-bits are driven and captured on the reference clock.
// - SS-SMII uses the transmit clock and the transmit sync pulse.
// - Eight independent ports, indexed 0 to 7.
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "ophy_params.svh"

module ophy_tx_port #(
  parameter int PORTS = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic crystal_in,
  output logic crystal_out_o,
  output logic crystal_out_oe_n,
  input wire logic shared_ref_clock_i,
  output logic shared_ref_clock_o,
  output logic shared_ref_clock_oe_n,
  input wire logic sync_pulse,
  input wire logic tx_sync,
  input wire logic [PORTS-1:0] txd0,
  input wire logic [PORTS-1:0] txd1,
  input wire logic [PORTS-1:0] tx_en,
  output logic [PORTS-1:0] seg_strobe,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  ophy_pkg::ophy_lnk_st_t ln_r;
  ophy_pkg::ophy_lnk_st_t ln_nxt;
  ophy_pkg::ophy_sys_st_t sy_r;
  ophy_pkg::ophy_sys_st_t sy_nxt;

  ophy_pkg::ophy_mode_t lnk_mode;
  logic lnk_run;
  logic lnk_boundary;
  logic [PORTS-1:0][`OPHY_SEG_BITS-1:0] lnk_word;
  logic [PORTS-1:0] lnk_tog;

  // Link domain: control crosses in as quasi-static levels through two flops.
  always_comb
  begin
    ln_nxt = ln_r;
    ln_nxt.rs = {ln_r.rs[0], 1'b1};
    ln_nxt.mode_m = sy_r.ctrl[`OPHY_CTRL_MODE_LSB +: 2];
    ln_nxt.mode_s = ln_r.mode_m;
    ln_nxt.spd_m = sy_r.ctrl[`OPHY_CTRL_SPD_BIT];
    ln_nxt.spd_s = ln_r.spd_m;
    ln_nxt.en_m = sy_r.ctrl[7:0];
    ln_nxt.en_s = ln_r.en_m;
    ln_nxt.ce_m = ce;
    ln_nxt.ce_s = ln_r.ce_m;
  end

  // The link reset is asserted at once and released only after two link edges,
  // so a clock that stops outside frames cannot leave half a release behind.
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ln_r <= '0;
    end
    else
    begin
      ln_r <= ln_nxt;
    end
  end

  always_comb
  begin
    unique case (ln_r.mode_s)
      2'h1:
      begin
        lnk_mode = ophy_pkg::ophy_mode_smii;
      end
      2'h2:
      begin
        lnk_mode = ophy_pkg::ophy_mode_ssmii;
      end
      default:
      begin
        lnk_mode = ophy_pkg::ophy_mode_rmii;
      end
    endcase
  end

  assign lnk_run = ln_r.rs[1] && ln_r.ce_s;
  // Segment boundaries come from the transmit sync in SS-SMII, else the shared sync.
  assign lnk_boundary = (lnk_mode == ophy_pkg::ophy_mode_ssmii) ? tx_sync : sync_pulse;

  generate
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
      ophy_port_if pif ();

      assign pif.mode = lnk_mode;
      assign pif.run = lnk_run;
      assign pif.enable = ln_r.en_s[p];
      assign pif.speed_10 = ln_r.spd_s;
      assign pif.boundary = lnk_boundary;
      assign pif.txd0 = txd0[p];
      assign pif.txd1 = txd1[p];
      assign pif.tx_en = tx_en[p];
      assign lnk_word[p] = pif.word;
      assign lnk_tog[p] = pif.tog;

      ophy_port_cap u_cap (
        .link_clk(link_clk),
        .rst_n(rst_n),
        .pif(pif)
      );
    end
  endgenerate

  // System domain.
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] sticky_clr;
  logic [31:0] rd_val;
  logic word_hit;
  logic [2:0] word_idx;

  always_comb
  begin
    bus_req = wb_cyc_i && wb_stb_i && !sy_r.ack;
    bus_wr = bus_req && wb_we_i;
    bus_rd = bus_req && !wb_we_i;
    word_hit = (wb_adr_i >= `OPHY_WORD_OFS) && (wb_adr_i < `OPHY_WORD_END)
      && (wb_adr_i[1:0] == 2'h0);
    word_idx = wb_adr_i[4:2];
    sticky_clr = 8'h00;
    if (bus_wr && wb_adr_i == `OPHY_STAT_OFS && wb_sel_i[1])
    begin
      sticky_clr = wb_dat_i[15:8];
    end
    rd_val = 32'h0000_0000;
    if (wb_adr_i == `OPHY_CTRL_OFS)
    begin
      rd_val = {21'h00_0000, sy_r.ctrl};
    end
    else if (wb_adr_i == `OPHY_STAT_OFS)
    begin
      rd_val = {16'h0000, sy_r.sticky, 7'h00, sy_r.xtal_act};
    end
    else if (word_hit)
    begin
      rd_val = {22'h00_0000, sy_r.word[word_idx]};
    end
  end

  always_comb
  begin
    sy_nxt = sy_r;
    if (ce)
    begin
      // Bus slave: one ack per request, one cycle after the strobe is seen.
      sy_nxt.ack = bus_req;
      if (bus_rd)
      begin
        sy_nxt.rdat = rd_val;
      end
      if (bus_wr && wb_adr_i == `OPHY_CTRL_OFS)
      begin
        if (wb_sel_i[0])
        begin
          sy_nxt.ctrl[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          sy_nxt.ctrl[10:8] = wb_dat_i[10:8];
        end
      end

      // Word crossing: the link holds a word steady across its toggle, and the
      // toggle is compared only after the second flop.
      sy_nxt.tog_m = lnk_tog;
      sy_nxt.tog_s = sy_r.tog_m;
      sy_nxt.tog_d = sy_r.tog_s;
      sy_nxt.strobe = sy_r.tog_s ^ sy_r.tog_d;
      for (int i = 0; i < PORTS; i++)
      begin
        if (sy_r.tog_s[i] != sy_r.tog_d[i])
        begin
          sy_nxt.word[i] = lnk_word[i];
        end
      end
      // A new word arriving with a clear keeps its flag.
      sy_nxt.sticky = (sy_r.sticky & ~sticky_clr) | (sy_r.tog_s ^ sy_r.tog_d);

      // Crystal activity: edges of the synchronised input within a window.
      sy_nxt.xtal_m = crystal_in;
      sy_nxt.xtal_s = sy_r.xtal_m;
      sy_nxt.xtal_d = sy_r.xtal_s;
      if (sy_r.xtal_s != sy_r.xtal_d)
      begin
        sy_nxt.xtal_cnt = 6'h00;
        sy_nxt.xtal_act = 1'b1;
      end
      else if (sy_r.xtal_cnt == `OPHY_XTAL_WIN)
      begin
        sy_nxt.xtal_act = 1'b0;
      end
      else
      begin
        sy_nxt.xtal_cnt = sy_r.xtal_cnt + 6'h01;
      end

      // Reference output: a five-step pattern gives two periods per five
      // system cycles, 50 MHz on average with one cycle of jitter.
      sy_nxt.ref_pat = {sy_r.ref_pat[0], sy_r.ref_pat[4:1]};
      sy_nxt.ref_o = sy_r.xtal_act && sy_r.ref_pat[0];
      // The pin turns to an input once the crystal stops.
      sy_nxt.ref_oe_n = !sy_r.xtal_act;
      sy_nxt.cry_out = sy_r.xtal_act && !sy_r.xtal_s;
    end
  end

  // The chip reset is taken as given; its minimum length is the board's duty.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy_r <= '0;
      sy_r.ctrl <= `OPHY_CTRL_RST;
      sy_r.ref_pat <= `OPHY_REF_PATTERN;
      sy_r.ref_oe_n <= 1'b1;
    end
    else
    begin
      sy_r <= sy_nxt;
    end
  end

  assign wb_ack_o = sy_r.ack;
  assign wb_dat_o = sy_r.rdat;
  assign seg_strobe = sy_r.strobe;
  assign shared_ref_clock_o = sy_r.ref_o;
  assign shared_ref_clock_oe_n = sy_r.ref_oe_n;
  assign crystal_out_o = sy_r.cry_out;
  assign crystal_out_oe_n = sy_r.ref_oe_n;

endmodule : ophy_tx_port

`default_nettype wire

// ===== inc/ophy_params.svh
// Constants of the octal transmit port: register map, fields, reset values and counts.
// Assumes a 32-bit classic Wishbone slave decoding byte addresses in eight address bits.
`ifndef OPHY_PARAMS_SVH
`define OPHY_PARAMS_SVH

`define OPHY_CTRL_OFS 8'h00
`define OPHY_STAT_OFS 8'h04
`define OPHY_WORD_OFS 8'h20
`define OPHY_WORD_END 8'h40

`define OPHY_CTRL_RST 11'h0FF
`define OPHY_CTRL_MODE_LSB 8
`define OPHY_CTRL_SPD_BIT 10

`define OPHY_SEG_BITS 10
`define OPHY_SEG_LAST 4'h9
`define OPHY_RMII_LAST 4'h3
`define OPHY_REP_LAST 4'h9

`define OPHY_XTAL_WIN 6'h3F
`define OPHY_REF_PATTERN 5'h0D
`define OPHY_RESET_MIN_MS 10

`endif

// ===== inc/ophy_pkg.sv
// Types of the octal transmit port: modes and the state records of each module.
// Assumes ophy_params.svh is on the include path.
`include "ophy_params.svh"

package ophy_pkg;

  typedef enum logic [1:0] {ophy_mode_rmii, ophy_mode_smii, ophy_mode_ssmii} ophy_mode_t;

  typedef struct packed {
    logic [`OPHY_SEG_BITS-1:0] sh;
    logic [3:0] cnt;
    logic [3:0] rep;
    logic [`OPHY_SEG_BITS-1:0] word;
    logic tog;
  } ophy_cap_st_t;

  typedef struct packed {
    logic [1:0] rs;
    logic [1:0] mode_m;
    logic [1:0] mode_s;
    logic spd_m;
    logic spd_s;
    logic [7:0] en_m;
    logic [7:0] en_s;
    logic ce_m;
    logic ce_s;
  } ophy_lnk_st_t;

  typedef struct packed {
    logic [10:0] ctrl;
    logic [7:0] sticky;
    logic [7:0][`OPHY_SEG_BITS-1:0] word;
    logic ack;
    logic [31:0] rdat;
    logic [7:0] tog_m;
    logic [7:0] tog_s;
    logic [7:0] tog_d;
    logic [7:0] strobe;
    logic xtal_m;
    logic xtal_s;
    logic xtal_d;
    logic [5:0] xtal_cnt;
    logic xtal_act;
    logic [4:0] ref_pat;
    logic ref_o;
    logic ref_oe_n;
    logic cry_out;
  } ophy_sys_st_t;

endpackage : ophy_pkg

// ===== inc/ophy_port_if.sv
// Carrier between the link-side control of the top and one port's capture logic.
// Assumes all signals live in the link clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "ophy_params.svh"

interface ophy_port_if;
  ophy_pkg::ophy_mode_t mode;
  logic run;
  logic enable;
  logic speed_10;
  logic boundary;
  logic txd0;
  logic txd1;
  logic tx_en;
  logic [`OPHY_SEG_BITS-1:0] word;
  logic tog;

  modport cap (input mode, run, enable, speed_10, boundary, txd0, txd1, tx_en,
    output word, tog);
  modport top (output mode, run, enable, speed_10, boundary, txd0, txd1, tx_en,
    input word, tog);
endinterface : ophy_port_if

`default_nettype wire

// ===== design/ophy_port_cap.sv
// One port's transmit capture: di-bits in RMII, 10-bit segments in SMII and SS-SMII.
// Assumes its pins are synchronous to link_clk and that the word is read through a toggle.
`timescale 1ns/100ps
`default_nettype none
`include "ophy_params.svh"

module ophy_port_cap (
  input wire logic link_clk,
  input wire logic rst_n,
  ophy_port_if.cap pif
);

  ophy_pkg::ophy_cap_st_t st_r;
  ophy_pkg::ophy_cap_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (pif.run && !pif.enable)
    begin
      st_nxt.cnt = 4'h0;
      st_nxt.rep = 4'h0;
    end
    else if (pif.run)
    begin
      unique case (pif.mode)
        ophy_pkg::ophy_mode_rmii:
        begin
          if (pif.tx_en)
          begin
            st_nxt.sh = {pif.txd1, pif.txd0, st_r.sh[`OPHY_SEG_BITS-1:2]};
            if (st_r.cnt == `OPHY_RMII_LAST)
            begin
              st_nxt.cnt = 4'h0;
              st_nxt.word = {2'h0, pif.txd1, pif.txd0, st_r.sh[`OPHY_SEG_BITS-1:4]};
              st_nxt.tog = ~st_r.tog;
            end
            else
            begin
              st_nxt.cnt = st_r.cnt + 4'h1;
            end
          end
          else
          begin
            st_nxt.cnt = 4'h0;
          end
        end
        default:
        begin
          // The enable pin carries nothing here and is ignored.
          st_nxt.sh = {pif.txd0, st_r.sh[`OPHY_SEG_BITS-1:1]};
          if (pif.boundary)
          begin
            st_nxt.cnt = 4'h1;
          end
          else if (st_r.cnt == `OPHY_SEG_LAST)
          begin
            st_nxt.cnt = 4'h0;
            if (!pif.speed_10 || st_r.rep == 4'h0)
            begin
              st_nxt.word = {pif.txd0, st_r.sh[`OPHY_SEG_BITS-1:1]};
              st_nxt.tog = ~st_r.tog;
            end
            st_nxt.rep = (!pif.speed_10 || st_r.rep == `OPHY_REP_LAST) ? 4'h0 : st_r.rep + 4'h1;
          end
          else if (st_r.cnt != 4'h0)
          begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end
        end
      endcase
    end
  end

  // Pins are taken on the rising edge of the clock that times them.
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign pif.word = st_r.word;
  assign pif.tog = st_r.tog;

endmodule : ophy_port_cap

`default_nettype wire

// ===== verification/ophy_tx_port_sva.sv
// Checker of the octal transmit port: bus answer, strobes and reference pin.
// Assumes it sees only the top module's ports, through the bind below.
`timescale 1ns/100ps
`default_nettype none

module ophy_sva #(parameter int PORTS = 8) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic crystal_in,
  input wire logic crystal_out_o,
  input wire logic crystal_out_oe_n,
  input wire logic shared_ref_clock_o,
  input wire logic shared_ref_clock_oe_n,
  input wire logic [PORTS-1:0] seg_strobe,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  logic [6:0] still_r;
  logic [6:0] still_nxt;
  logic xq_r;

  // Saturates so that a long stop cannot wrap back into the window.
  always_comb still_nxt = (crystal_in != xq_r) ? 7'h00 : (&still_r ? still_r : still_r + 7'h01);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      still_r <= 7'h00;
      xq_r <= 1'b0;
    end
    else
    begin
      still_r <= still_nxt;
      xq_r <= crystal_in;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  // A frozen clock enable would stretch every pulse, so it pauses the checks.
  default disable iff (!rst_n || !ce);

  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_resp; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle on");
  property p_stb_once; seg_strobe != '0 |=> (seg_strobe & $past(seg_strobe)) == '0; endproperty
  a_stb_once: assert property (p_stb_once) else $error("strobe held");
  property p_oe_same; crystal_out_oe_n == shared_ref_clock_oe_n; endproperty
  a_oe_same: assert property (p_oe_same) else $error("enables differ");
  property p_ref_quiet; shared_ref_clock_oe_n |-> !shared_ref_clock_o; endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("ref driven while input");
  property p_ref_hi; !shared_ref_clock_oe_n && shared_ref_clock_o && $past(shared_ref_clock_o)
    |=> !shared_ref_clock_o; endproperty
  a_ref_hi: assert property (p_ref_hi) else $error("ref high three cycles");
  property p_ref_lo; !shared_ref_clock_oe_n && $past(!shared_ref_clock_oe_n, 2)
    && !shared_ref_clock_o |-> $past(shared_ref_clock_o); endproperty
  a_ref_lo: assert property (p_ref_lo) else $error("ref low two cycles");
  property p_xt_stop; still_r >= 7'h50 |-> shared_ref_clock_oe_n; endproperty
  a_xt_stop: assert property (p_xt_stop) else $error("ref out with crystal stopped");
  property p_xo_quiet; crystal_out_oe_n |-> !crystal_out_o; endproperty
  a_xo_quiet: assert property (p_xo_quiet) else $error("crystal out high while floating");
endmodule : ophy_sva

bind ophy_tx_port ophy_sva #(.PORTS(PORTS)) i_ophy_sva (.clk_sys(clk_sys), .rst_n(rst_n),
  .ce(ce), .crystal_in(crystal_in), .crystal_out_o(crystal_out_o),
  .crystal_out_oe_n(crystal_out_oe_n),
  .shared_ref_clock_o(shared_ref_clock_o), .shared_ref_clock_oe_n(shared_ref_clock_oe_n),
  .seg_strobe(seg_strobe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

`default_nettype wire

// ===== verification/ophy_mac_model.sv
// Behavioural MAC driving the transmit pins in RMII, SMII and SS-SMII.
// Assumes its clock is the one that times the selected mode.
`timescale 1ns/100ps
`default_nettype none

module ophy_mac_model (
  input wire logic link_clk,
  output logic sync_pulse,
  output logic tx_sync,
  output logic [7:0] txd0,
  output logic [7:0] txd1,
  output logic [7:0] tx_en
);
  initial
  begin
    sync_pulse = 1'b0;
    tx_sync = 1'b0;
    txd0 = 8'h00;
    txd1 = 8'h00;
    tx_en = 8'h00;
  end

  // Released data lines flip, so a stale bit is never mistaken for data.
  task automatic idle();
    @(posedge link_clk);
    sync_pulse <= 1'b0;
    tx_sync <= 1'b0;
    tx_en <= 8'h00;
    txd0 <= ~txd0;
    txd1 <= ~txd1;
  endtask : idle

  task automatic send_byte(input int p, input logic [7:0] b);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge link_clk);
      tx_en[p] <= 1'b1;
      txd0[p] <= b[2*i];
      txd1[p] <= b[2*i+1];
    end
    idle();
  endtask : send_byte

  // Serial segments leave the enable pins alone.
  task automatic send_seg(input logic ss, input int p, input logic [9:0] w, input int n);
    for (int r = 0; r < n; r++)
      for (int i = 0; i < 10; i++)
      begin
        @(posedge link_clk);
        sync_pulse <= !ss && i == 0;
        tx_sync <= ss && i == 0;
        txd0[p] <= w[i];
      end
    idle();
  endtask : send_seg
endmodule : ophy_mac_model

`default_nettype wire

// ===== verification/tb_ophy_tx_port.sv
// Testbench of the octal transmit port: bus tasks, one task per scenario, verdict.
// Assumes the MAC model and the checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module tb_ophy_tx_port;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic rst_n = 1'b0;
  logic xtal_drv = 1'b0;
  logic ce_drv = 1'b1;
  logic we = 1'b0;
  logic stb = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic ack, xoe, roe, ro, syn, tsyn;
  logic [7:0] d0, d1, en;
  int err_total = 0;
  int num_checks = 0;

  initial forever #4 clk_sys = ~clk_sys;
  initial
  begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  ophy_mac_model i_ophy_mac_model (.link_clk(link_clk), .sync_pulse(syn), .tx_sync(tsyn),
    .txd0(d0), .txd1(d1), .tx_en(en));
  ophy_tx_port i_ophy_tx_port (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce_drv),
    .link_clk(link_clk), .crystal_in(xtal_drv), .crystal_out_o(), .crystal_out_oe_n(xoe),
    .shared_ref_clock_i(link_clk), .shared_ref_clock_o(ro), .shared_ref_clock_oe_n(roe),
    .sync_pulse(syn), .tx_sync(tsyn), .txd0(d0), .txd1(d1), .tx_en(en), .seg_strobe(),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(stb),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    adr <= a;
    wdat <= d;
    we <= w;
    stb <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 40);
    rd = rdat;
    stb <= 1'b0;
    if (ack !== 1'b1)
      chk(32'h1, 32'h0);
  endtask : wb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // Mode and enables cross as levels, so traffic waits for them to settle.
  task automatic ctrl(input logic [31:0] v);
    wb(1'b1, 8'h00, v);
    repeat (4) @(posedge link_clk);
  endtask : ctrl

  task automatic t_xtal();
    rdchk(8'h00, 32'h000000FF);
    rdchk(8'h80, 32'h0);
    chk({31'h0, roe}, 32'h1);
    repeat (40)
    begin
      repeat (2) @(posedge clk_sys);
      xtal_drv <= ~xtal_drv;
    end
    rdchk(8'h04, 32'h1);
    chk({30'h0, roe, xoe}, 32'h0);
    repeat (90) @(posedge clk_sys);
    chk({31'h0, roe}, 32'h1);
  endtask : t_xtal

  task automatic t_rmii();
    ctrl(32'h000000FF);
    i_ophy_mac_model.send_byte(3, 8'hA5);
    i_ophy_mac_model.send_byte(7, 8'h3C);
    repeat (8) @(posedge clk_sys);
    rdchk(8'h2C, 32'h000000A5);
    rdchk(8'h3C, 32'h0000003C);
    rdchk(8'h04, 32'h00008800);
    wb(1'b1, 8'h04, 32'h0000FF00);
    // A frozen block must not take a byte that the MAC sends meanwhile.
    @(posedge clk_sys);
    ce_drv <= 1'b0;
    repeat (4) @(posedge link_clk);
    i_ophy_mac_model.send_byte(2, 8'h5A);
    repeat (4) @(posedge link_clk);
    @(posedge clk_sys);
    ce_drv <= 1'b1;
    repeat (4) @(posedge link_clk);
    rdchk(8'h28, 32'h00000000);
    rdchk(8'h04, 32'h00000000);
  endtask : t_rmii

  task automatic t_serial();
    ctrl(32'h000001FF);
    i_ophy_mac_model.send_seg(1'b0, 5, 10'h2B6, 1);
    repeat (8) @(posedge clk_sys);
    rdchk(8'h34, 32'h000002B6);
    ctrl(32'h00000500);
    ctrl(32'h000005FF);
    i_ophy_mac_model.send_seg(1'b0, 0, 10'h155, 10);
    repeat (8) @(posedge clk_sys);
    rdchk(8'h20, 32'h00000155);
    i_ophy_mac_model.send_seg(1'b0, 0, 10'h0CC, 10);
    repeat (8) @(posedge clk_sys);
    rdchk(8'h20, 32'h000000CC);
    ctrl(32'h000002FF);
    i_ophy_mac_model.send_seg(1'b1, 6, 10'h19B, 1);
    i_ophy_mac_model.send_seg(1'b0, 6, 10'h3C3, 1);
    repeat (8) @(posedge clk_sys);
    rdchk(8'h38, 32'h0000019B);
  endtask : t_serial

  task automatic wrap_up();
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (2) @(posedge link_clk);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    t_xtal();
    t_rmii();
    t_serial();
    wrap_up();
  end

  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule : tb_ophy_tx_port

`default_nettype wire
